// ### include/pcm_regs.svh
// Register map, field positions, reset values and timing figures of the PLL control block
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// Word offsets inside one channel window
`define PCM_REG_CTRL      4'h0
`define PCM_REG_MULT      4'h4
`define PCM_REG_SHIFT     4'h8
`define PCM_REG_STATUS    4'hC

// Control bits
`define PCM_CTRL_ENABLE   0
`define PCM_CTRL_USE_ENA  1
`define PCM_CTRL_LOCK_PIN 2
`define PCM_CTRL_CLK_PIN  3
`define PCM_CTRL_EXT_FB   4
`define PCM_CTRL_SERIAL   5
`define PCM_CTRL_GPIO_OD  6
`define PCM_CTRL_GPIO_VAL 7
`define PCM_CTRL_GPIO_OE  8
`define PCM_CTRL_W        9

// Multiplier limits and reset values
`define PCM_M_MIN         8'h02
`define PCM_M_MAX         8'hA0
`define PCM_N_MIN         5'h01
`define PCM_N_MAX         5'h10
`define PCM_K_MIN         8'h02
`define PCM_K_MAX         8'hA0

// Lock figures
`define PCM_LOCK_TIME_NS  40000
`define PCM_CLK_PERIOD_PS 4000
`define PCM_REF_LIMIT     2000

`endif

// ### include/pcm_pkg.sv
// Types shared by the PLL control block
package pcm_pkg;
	typedef logic [31:0] pcm_word_t;
	typedef enum logic [1:0] {PCM_IDLE, PCM_ACQ, PCM_LOCK} pcm_state_t;
endpackage : pcm_pkg

// ### design/pcm_synth.sv
// One digitally synthesised clock output with phase and delay offset
`timescale 1ns/1ps
module pcm_synth (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	// Settings
	input  wire logic        run_in,
	input  wire logic        align_in,
	input  wire logic [15:0] period_in,
	input  wire logic [7:0]  mult_in,
	input  wire logic [11:0] div_in,
	input  wire logic [1:0]  quarter_in,
	input  wire logic signed [16:0] delay_in,
	// Generated clock
	output logic             clk_out
);
	import pcm_pkg::*;

	logic        [27:0] phase;
	logic        [27:0] next_phase;
	logic               next_clk;
	logic        [29:0] thr;
	logic signed [29:0] dly;
	logic        [29:0] off;
	logic        [29:0] acc;
	logic        [29:0] pos;

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		thr = 30'(period_in) * 30'(div_in);
		dly = 30'(delay_in) * $signed({22'h0, mult_in});
		if (dly > $signed(thr))
			dly = $signed(thr);
		if (dly < -$signed(thr))
			dly = -$signed(thr);
		off = 30'(quarter_in) * (thr >> 2) + thr - 30'(dly);
		if (off >= thr)
			off = off - thr;
		if (off >= thr)
			off = off - thr;
		// rate m over n times k
		acc = 30'(phase) + 30'(mult_in);
		if (acc >= thr)
			acc = acc - thr;
		next_phase = acc[27:0];
		if (align_in || !run_in)
			next_phase = 28'h0;
		pos = 30'(phase) + off;
		if (pos >= thr)
			pos = pos - thr;
		next_clk = run_in && (pos < (thr >> 1));
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase   <= 28'h0;
			clk_out <= 1'b0;
		end else if (ce_in) begin
			phase   <= next_phase;
			clk_out <= next_clk;
		end
	end
endmodule : pcm_synth

// ### design/pcm_pll_ctrl.sv
// Control of up to four independent PLLs with lock tracking and pin routing
// Notes on behaviour
// - Output rate equals input rate times m over n times k, m,k 2..160.
// - Output phase selectable in ninety degree quarter-period steps.
// - Delay shift earlier or later by at most one output period.
// - Lock indication goes high once lock on reference acquired.
// - Lock pin optional; when unused it acts as general-purpose pin.
// - Reference clock ignored until configuration has finished.
// - Acquisition starts at configuration end; generated clock usable at once.
// - Generated clock can be driven out on a pin.
// - Feedback can run through an external board path.
// - Up to four PLLs, each with own settings and lock.
// - Two PLLs may do serial capture; the others general clocking only.
// - Serial mode multiplies forwarded clock to the bit rate.
// - No pin driven before configuration completes.
// - Open-drain pin drives only low or releases, never high.
// - Lock within 40 us or 2000 reference cycles, whichever first.
// - PLLs disabled before and throughout configuration.
// - With enable pin in use, acquisition waits for it high.
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "pcm_regs.svh"
module pcm_pll_ctrl #(
	parameter int NUM_PLL             = 4,
	parameter int SERIAL_PLLS         = 2,
	parameter int STABLE_EDGES        = 16,
	parameter int PERIOD_TOL          = 2,
	parameter int REF_LIMIT           = `PCM_REF_LIMIT,
	parameter int LOCK_TIMEOUT_CYCLES = (`PCM_LOCK_TIME_NS * 1000) / `PCM_CLK_PERIOD_PS
) (
	// Clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               ce_in,
	// Device state
	input  wire logic               config_done_in,
	// Wishbone slave
	input  wire logic               wb_cyc_in,
	input  wire logic               wb_stb_in,
	input  wire logic               wb_we_in,
	input  wire logic [7:0]         wb_adr_in,
	input  wire logic [3:0]         wb_sel_in,
	input  wire pcm_pkg::pcm_word_t wb_dat_in,
	output pcm_pkg::pcm_word_t      wb_dat_out,
	output logic                    wb_ack_out,
	// Per PLL pins
	input  wire logic [NUM_PLL-1:0] ref_clk_in,
	input  wire logic [NUM_PLL-1:0] fb_clk_in,
	input  wire logic [NUM_PLL-1:0] pll_enable_input_in,
	input  wire logic [NUM_PLL-1:0] lock_pin_in,
	output logic      [NUM_PLL-1:0] lock_pin_out,
	output logic      [NUM_PLL-1:0] lock_pin_oe_out,
	output logic      [NUM_PLL-1:0] clk_pin_out,
	output logic      [NUM_PLL-1:0] clk_pin_oe_out,
	output logic      [NUM_PLL-1:0] core_clk_out,
	output logic      [NUM_PLL-1:0] locked_out
);
	import pcm_pkg::*;

	localparam int TMW = $clog2(LOCK_TIMEOUT_CYCLES + 1);

	//////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_ff1;
	logic rst_ff2;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_ff1 <= 1'b0;
			rst_ff2 <= 1'b0;
		end else if (ce_in) begin
			rst_ff1 <= 1'b1;
			rst_ff2 <= rst_ff1;
		end
	end
	wire logic rst_n = rst_ff2;

	//////////////////////////////////////////////////////////////////////////
	// Register file
	logic [`PCM_CTRL_W-1:0] ctrl       [NUM_PLL];
	logic [`PCM_CTRL_W-1:0] next_ctrl  [NUM_PLL];
	logic [7:0]             m_val      [NUM_PLL];
	logic [7:0]             next_m_val [NUM_PLL];
	logic [4:0]             n_val      [NUM_PLL];
	logic [4:0]             next_n_val [NUM_PLL];
	logic [7:0]             k_val      [NUM_PLL];
	logic [7:0]             next_k_val [NUM_PLL];
	logic [1:0]             quarter    [NUM_PLL];
	logic [1:0]             next_quarter [NUM_PLL];
	logic [15:0]            delay      [NUM_PLL];
	logic [15:0]            next_delay [NUM_PLL];
	logic [NUM_PLL-1:0]     chg;
	logic [NUM_PLL-1:0]     next_chg;
	logic                   next_ack;
	pcm_word_t              next_dat;
	pcm_word_t              wmask;
	pcm_word_t              cur;
	pcm_word_t              wval;
	pcm_state_t             state      [NUM_PLL];
	logic [15:0]            period     [NUM_PLL];
	logic [1:0]             ch;
	logic [3:0]             reg_off;
	logic                   mapped;
	logic                   req;

	always_comb begin
		ch       = wb_adr_in[5:4];
		reg_off  = {wb_adr_in[3:2], 2'b00};
		mapped   = (wb_adr_in[7:6] == 2'b00) && (32'(ch) < NUM_PLL);
		// One-cycle answer; the register drops ack the cycle after it rose
		req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
		next_ack = req;
		next_dat = 32'h0;
		wmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
		cur      = 32'h0;
		wval     = 32'h0;
		next_chg = '0;
		for (int i = 0; i < NUM_PLL; i++) begin
			next_ctrl[i]    = ctrl[i];
			next_m_val[i]   = m_val[i];
			next_n_val[i]   = n_val[i];
			next_k_val[i]   = k_val[i];
			next_quarter[i] = quarter[i];
			next_delay[i]   = delay[i];
		end
		if (req && mapped) begin
			case (reg_off)
				`PCM_REG_CTRL: cur = 32'(ctrl[ch]);
				`PCM_REG_MULT: cur = {8'h0, k_val[ch], 3'h0, n_val[ch], m_val[ch]};
				`PCM_REG_SHIFT: cur = {delay[ch], 14'h0, quarter[ch]};
				`PCM_REG_STATUS: cur = {period[ch], 13'h0, lock_pin_in[ch],
					state[ch] == PCM_ACQ, locked_out[ch]};
				default: cur = 32'h0;
			endcase
			next_dat = wb_we_in ? 32'h0 : cur;
			wval     = (cur & ~wmask) | (wb_dat_in & wmask);
			if (wb_we_in) begin
				case (reg_off)
					`PCM_REG_CTRL: begin
						next_ctrl[ch] = wval[`PCM_CTRL_W-1:0];
						if (32'(ch) >= SERIAL_PLLS)
							next_ctrl[ch][`PCM_CTRL_SERIAL] = 1'b0;
						next_chg[ch] = 1'b1;
					end
					`PCM_REG_MULT: begin
						next_m_val[ch] = (wval[7:0] < `PCM_M_MIN) ? `PCM_M_MIN :
							(wval[7:0] > `PCM_M_MAX) ? `PCM_M_MAX : wval[7:0];
						next_n_val[ch] = (wval[12:8] < `PCM_N_MIN) ? `PCM_N_MIN :
							(wval[12:8] > `PCM_N_MAX) ? `PCM_N_MAX : wval[12:8];
						next_k_val[ch] = (wval[23:16] < `PCM_K_MIN) ? `PCM_K_MIN :
							(wval[23:16] > `PCM_K_MAX) ? `PCM_K_MAX : wval[23:16];
						next_chg[ch] = 1'b1;
					end
					`PCM_REG_SHIFT: begin
						next_quarter[ch] = wval[1:0];
						next_delay[ch]   = wval[31:16];
						next_chg[ch]     = 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
			chg        <= '0;
			for (int i = 0; i < NUM_PLL; i++) begin
				ctrl[i]    <= '0;
				m_val[i]   <= `PCM_M_MIN;
				n_val[i]   <= `PCM_N_MIN;
				k_val[i]   <= `PCM_K_MIN;
				quarter[i] <= 2'h0;
				delay[i]   <= 16'h0;
			end
		end else if (ce_in) begin
			wb_ack_out <= next_ack;
			wb_dat_out <= next_dat;
			chg        <= next_chg;
			for (int i = 0; i < NUM_PLL; i++) begin
				ctrl[i]    <= next_ctrl[i];
				m_val[i]   <= next_m_val[i];
				n_val[i]   <= next_n_val[i];
				k_val[i]   <= next_k_val[i];
				quarter[i] <= next_quarter[i];
				delay[i]   <= next_delay[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// independent channels
	for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll
		logic             ref_prev, fb_prev;
		logic [15:0]      per_cnt, next_per_cnt, next_period;
		logic [15:0]      lag_cnt, next_lag_cnt, fb_lag, next_fb_lag;
		logic [7:0]       stable, next_stable;
		logic [10:0]      edges, next_edges;
		logic [TMW-1:0]   timer, next_timer;
		pcm_state_t       next_state;
		logic             ref_edge, fb_edge, active, off_tol, early, late;
		logic [11:0]      div;
		logic signed [16:0] dly_eff;
		logic             gen_clk;

		always_comb begin
			ref_edge = config_done_in && ref_clk_in[g] && !ref_prev;
			fb_edge  = config_done_in && fb_clk_in[g] && !fb_prev;
			// held off until configured; enable pin gate
			active   = config_done_in && ctrl[g][`PCM_CTRL_ENABLE] &&
				(!ctrl[g][`PCM_CTRL_USE_ENA] || pll_enable_input_in[g]);
			early    = 17'(per_cnt) + 17'(PERIOD_TOL) < 17'(period[g]);
			late     = 17'(per_cnt) > 17'(period[g]) + 17'(PERIOD_TOL);
			off_tol  = early || late;
			next_per_cnt = (per_cnt == 16'hFFFF) ? per_cnt : per_cnt + 16'h1;
			next_lag_cnt = (lag_cnt == 16'hFFFF) ? lag_cnt : lag_cnt + 16'h1;
			next_fb_lag  = fb_lag;
			next_period  = period[g];
			next_stable  = stable;
			next_edges   = edges;
			next_timer   = timer;
			next_state   = state[g];
			if (ref_edge) begin
				next_per_cnt = 16'h1;
				next_lag_cnt = 16'h1;
			end
			if (fb_edge)
				next_fb_lag = lag_cnt;
			case (state[g])
				PCM_IDLE: begin
					if (active) begin
						next_state  = PCM_ACQ;
						next_stable = 8'h0;
						next_edges  = 11'h0;
						next_timer  = '0;
					end
				end
				PCM_ACQ: begin
					next_timer = timer + TMW'(1);
					if (ref_edge) begin
						next_period = per_cnt;
						next_edges  = edges + 11'h1;
						next_stable = off_tol ? 8'h0 : stable + 8'h1;
					end
					// lock bounded in time and edges
					if ((ref_edge && !off_tol && 32'(stable) + 1 >= STABLE_EDGES) ||
						(ref_edge && 32'(edges) + 1 >= REF_LIMIT) ||
						(32'(timer) + 1 >= LOCK_TIMEOUT_CYCLES && edges > 11'h1))
						next_state = PCM_LOCK;
				end
				PCM_LOCK: begin
					if (late || (ref_edge && early)) begin
						next_state  = PCM_ACQ;
						next_stable = 8'h0;
						next_edges  = 11'h0;
						next_timer  = '0;
					end
				end
				default: next_state = PCM_IDLE;
			endcase
			if (chg[g] && state[g] != PCM_IDLE) begin
				next_state  = PCM_ACQ;
				next_stable = 8'h0;
				next_edges  = 11'h0;
				next_timer  = '0;
			end
			if (!active)
				next_state = PCM_IDLE;
			div = ctrl[g][`PCM_CTRL_SERIAL] ? 12'h1 : 12'(n_val[g]) * 12'(k_val[g]);
			// external path shifts output earlier by its lag
			dly_eff = 17'($signed(delay[g]));
			if (ctrl[g][`PCM_CTRL_EXT_FB])
				dly_eff = dly_eff - $signed({1'b0, fb_lag});
		end

		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ref_prev  <= 1'b0;
				fb_prev   <= 1'b0;
				per_cnt   <= 16'h0;
				lag_cnt   <= 16'h0;
				fb_lag    <= 16'h0;
				period[g] <= 16'h0;
				stable    <= 8'h0;
				edges     <= 11'h0;
				timer     <= '0;
				state[g]  <= PCM_IDLE;
			end else if (ce_in) begin
				ref_prev  <= ref_clk_in[g];
				fb_prev   <= fb_clk_in[g];
				per_cnt   <= next_per_cnt;
				lag_cnt   <= next_lag_cnt;
				fb_lag    <= next_fb_lag;
				period[g] <= next_period;
				stable    <= next_stable;
				edges     <= next_edges;
				timer     <= next_timer;
				state[g]  <= next_state;
			end
		end

		pcm_synth u_synth (
			.clk_in     (clk_in),
			.rst_n_in   (rst_n),
			.ce_in      (ce_in),
			.run_in     (state[g] != PCM_IDLE && period[g] != 16'h0),
			.align_in   (ref_edge && state[g] == PCM_ACQ),
			.period_in  (period[g]),
			.mult_in    (m_val[g]),
			.div_in     (div),
			.quarter_in (quarter[g]),
			.delay_in   (dly_eff),
			.clk_out    (gen_clk)
		);

		assign locked_out[g]   = state[g] == PCM_LOCK;
		assign core_clk_out[g] = gen_clk;
		assign clk_pin_out[g]    = gen_clk;
		assign clk_pin_oe_out[g] = config_done_in && ctrl[g][`PCM_CTRL_CLK_PIN];
		// lock pin or general pin; open-drain never drives high
		assign lock_pin_out[g] = ctrl[g][`PCM_CTRL_LOCK_PIN] ? locked_out[g] :
			(!ctrl[g][`PCM_CTRL_GPIO_OD] && ctrl[g][`PCM_CTRL_GPIO_VAL]);
		assign lock_pin_oe_out[g] = config_done_in && (ctrl[g][`PCM_CTRL_LOCK_PIN] ||
			(ctrl[g][`PCM_CTRL_GPIO_OD] ? !ctrl[g][`PCM_CTRL_GPIO_VAL] :
			ctrl[g][`PCM_CTRL_GPIO_OE]));
	end
endmodule : pcm_pll_ctrl

// ### bench/pcm_pll_ctrl_assertions.sv
// Port-level assertions for the PLL control block
`timescale 1ns/1ps
module pcm_pll_ctrl_assertions #(parameter int NUM_PLL = 4) (
	// Clock and reset
	input wire logic               clk_in,
	input wire logic               rst_n_in,
	// Watched ports
	input wire logic               config_done_in,
	input wire logic               wb_cyc_in,
	input wire logic               wb_stb_in,
	input wire logic               wb_we_in,
	input wire logic [7:0]         wb_adr_in,
	input wire pcm_pkg::pcm_word_t wb_dat_out,
	input wire logic               wb_ack_out,
	input wire logic [NUM_PLL-1:0] lock_pin_oe_out,
	input wire logic [NUM_PLL-1:0] clk_pin_oe_out,
	input wire logic [NUM_PLL-1:0] core_clk_out,
	input wire logic [NUM_PLL-1:0] locked_out
);
	import pcm_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////
	chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("no ack after request");
	chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7:6] != 2'b00
		|-> wb_dat_out == '0) else $error("unmapped read not zero");
	chk_write_drops_lock: assert property (wb_ack_out && wb_we_in && wb_adr_in[7:6] == 2'b00
		&& wb_adr_in[3:2] != 2'b11 |=> !locked_out[$past(wb_adr_in[5:4])])
		else $error("lock kept after settings write");
	chk_cfg_no_lock: assert property (!config_done_in |=> locked_out == '0)
		else $error("lock while unconfigured");
	chk_cfg_no_drive: assert property (!config_done_in
		|-> lock_pin_oe_out == '0 && clk_pin_oe_out == '0) else $error("pin driven early");
	chk_cfg_clk_quiet: assert property (!config_done_in [*3] |-> core_clk_out == '0)
		else $error("clock runs while unconfigured");
	chk_lock_after_cfg: assert property ($rose(locked_out[0])
		|-> config_done_in && $past(config_done_in, 3)) else $error("lock too soon");
endmodule : pcm_pll_ctrl_assertions

// ### bench/pcm_ref_src.sv
// Reference clock source with a board feedback return per PLL
`timescale 1ns/1ps
module pcm_ref_src #(parameter int N = 4) (
	// Clock
	input wire logic        clk_in,
	// Control
	input wire logic [7:0]  half_in,
	input wire logic        glitch_in,
	// Clocks to the block
	output logic [N-1:0]    ref_clk_out,
	output logic [N-1:0]    fb_clk_out
);
	int cnt [N];
	int lim;
	logic [N-1:0] dly;
	initial begin
		ref_clk_out = '0;
		fb_clk_out = '0;
		dly = '0;
		foreach (cnt[i]) cnt[i] = i;
	end
	////////////////////////////////////////
	// steady period; glitch goes out of spec
	assign lim = glitch_in ? 3 * int'(half_in) : int'(half_in);
	always @(posedge clk_in) begin
		dly <= ref_clk_out;
		fb_clk_out <= dly;
		for (int i = 0; i < N; i++) begin
			if (cnt[i] + 1 >= lim) begin
				cnt[i] <= 0;
				ref_clk_out[i] <= ~ref_clk_out[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule : pcm_ref_src

// ### bench/pcm_pll_ctrl_tb_top.sv
// Self-checking bench for the PLL control block
`timescale 1ns/1ps
module pcm_pll_ctrl_tb_top;
	import pcm_pkg::*;
	localparam int N = 4;
	localparam int TO = 200;
	localparam int RL = 20;
	localparam int HALF = 5;
	// Shorter of edge limit and timeout, plus slack for start and output flops
	localparam int LMAX = ((RL * 2 * HALF < TO) ? RL * 2 * HALF : TO) + 8;
	logic clk, rst_n, cfg, cyc, stb, we, ack, glitch;
	logic [7:0] adr, half;
	logic [3:0] sel;
	pcm_word_t wdat, rdat;
	logic [N-1:0] rclk, fclk, ena, lin, lout, loe, cpin, coe, cclk, lck;
	int mismatches, total_checks, cycles;
	int mctl [N];
	int mmul [N];
	// Pull-up on the shared lock or general pin
	assign lin = (loe & lout) | ~loe;
	pcm_pll_ctrl #(.REF_LIMIT(RL), .LOCK_TIMEOUT_CYCLES(TO)) pcm_pll_ctrl_i (
		.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .config_done_in(cfg),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.ref_clk_in(rclk), .fb_clk_in(fclk), .pll_enable_input_in(ena),
		.lock_pin_in(lin), .lock_pin_out(lout), .lock_pin_oe_out(loe),
		.clk_pin_out(cpin), .clk_pin_oe_out(coe), .core_clk_out(cclk), .locked_out(lck));
	pcm_ref_src #(.N(N)) pcm_ref_src_i (.clk_in(clk), .half_in(half), .glitch_in(glitch),
		.ref_clk_out(rclk), .fb_clk_out(fclk));
	////////////////////////////////////////
	function automatic int clampv(int v, int lo, int hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : clampv
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	task automatic wb(input logic w, input logic [7:0] a, input pcm_word_t d,
		input logic [3:0] s, output pcm_word_t rd);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wr(input int ch, input int off, input int d, input logic [3:0] s);
		int m;
		pcm_word_t rd;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		wb(1'b1, 8'(ch * 16 + off), d, s, rd);
		if (off == 0) mctl[ch] = ((mctl[ch] & ~m) | (d & m)) & ((ch < 2) ? 'h1FF : 'h1DF);
		if (off == 4) begin
			d = (mmul[ch] & ~m) | (d & m);
			mmul[ch] = (clampv(d >> 16 & 255, 2, 160) << 16) | clampv(d & 255, 2, 160);
			mmul[ch] |= clampv(d >> 8 & 31, 1, 16) << 8;
		end
	endtask : wr
	task automatic rdchk(input string nm, input int a, input int e);
		pcm_word_t rd;
		wb(1'b0, 8'(a), '0, 4'hF, rd);
		check(nm, e, rd);
	endtask : rdchk
	task automatic wait_lock(input int ch, output int t);
		t = 0;
		while (lck[ch] !== 1'b1 && t < 2 * LMAX) begin
			@(posedge clk);
			t++;
		end
	endtask : wait_lock
	task automatic freq(input int ch, input int e);
		int t;
		int n;
		int np;
		logic p;
		logic q;
		wait_lock(ch, t);
		check("lock time", 1, t <= LMAX);
		n = 0;
		np = 0;
		p = cclk[ch];
		q = cpin[ch];
		repeat (200) begin
			@(posedge clk);
			n += (cclk[ch] === 1'b1 && p === 1'b0);
			np += (cpin[ch] === 1'b1 && q === 1'b0);
			p = cclk[ch];
			q = cpin[ch];
		end
		check("edges", 1, n >= e - 1 && n <= e + 1);
		check("pin edges", 1, coe[ch] === 1'b1 && np >= e - 1 && np <= e + 1);
	endtask : freq
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			stop_test();
		end
	end
	////////////////////////////////////////
	initial begin : main
		int t;
		int tot;
		pcm_word_t rd;
		{rst_n, cfg, cyc, stb, we, glitch} = '0;
		{adr, sel, wdat, ena} = '0;
		half = 8'(HALF);
		foreach (mctl[i]) begin
			mctl[i] = 0;
			mmul[i] = 'h20102;
		end
		void'($urandom(96));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int c = 0; c < N; c++) begin
			rdchk("ctrl reset", c * 16, 0);
			rdchk("mult reset", c * 16 + 4, 'h20102);
			rdchk("shift reset", c * 16 + 8, 0);
			wr(c, 0, 9 | ((c == 0) ? 4 : 0) | ((c == 3) ? 16 : 0), 4'hF);
		end
		repeat (300) @(posedge clk);
		check("lock unconfigured", 0, lck);
		check("oe unconfigured", 0, {loe, coe});
		$display("test preconfig done");
		cfg <= 1'b1;
		tot = 0;
		for (int c = 0; c < N; c++) begin
			wait_lock(c, t);
			tot += t;
			check("first lock", 1, tot <= LMAX);
		end
		check("clock pins", 'hF, coe);
		check("lock pin", 3, {loe[0], lout[0]});
		$display("test lock done");
		for (int i = 0; i < 8; i++) begin
			t = (i == 0) ? 'hFF0000 : (i == 1) ? 'h011FA1 : ($urandom & 'hFF1FFF);
			wr(i % N, 4, t, 4'hF);
			rdchk("mult", (i % N) * 16 + 4, mmul[i % N]);
		end
		wr(1, 4, 'hFFFFFF07, 4'h1);
		rdchk("mult byte", 'h14, mmul[1]);
		wr(2, 0, 'h29, 4'hF);
		rdchk("serial ch2", 'h20, mctl[2]);
		wb(1'b1, 8'h40, '1, 4'hF, rd);
		rdchk("unmapped", 'h40, 0);
		rdchk("ctrl kept", 0, mctl[0]);
		$display("test regs done");
		wr(0, 0, 'h2D, 4'hF);
		wr(0, 4, 'h20105, 4'hF);
		wr(1, 4, 'h20104, 4'hF);
		wr(1, 8, 'h30001, 4'hF);
		rdchk("shift", 'h18, 'h30001);
		wr(3, 4, 'h20102, 4'hF);
		freq(0, 200 * 5 / (2 * HALF));
		freq(1, 200 * 4 / (2 * HALF * 2));
		freq(3, 200 * 2 / (2 * HALF * 2));
		$display("test rate done");
		wr(2, 0, 3, 4'hF);
		repeat (300) @(posedge clk);
		check("held by pin", 0, lck[2]);
		// far side enables in user mode
		ena[2] <= 1'b1;
		wait_lock(2, t);
		check("lock after pin", 1, t <= LMAX);
		for (int v = 0; v < 4; v++) begin
			wr(3, 0, 'h11 | (v << 6) | ((v & 1) ? 0 : 'h100), 4'hF);
			@(posedge clk);
			check("pin oe", (v & 1) ? (v < 2) : 1, loe[3]);
			check("pin out", (v & 1) ? 0 : v >> 1, lout[3]);
			wb(1'b0, 8'h3C, '0, 4'hF, rd);
			check("pin level", v >> 1, rd[2]);
			check("status acquiring", 2, rd[1:0]);
			check("ref period", 2 * HALF, rd[31:16]);
		end
		$display("test pins done");
		check("locked before loss", 1, lck[1]);
		glitch <= 1'b1;
		t = 0;
		while (lck[1] === 1'b1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		check("lock lost", 1, t < 100);
		glitch <= 1'b0;
		wait_lock(1, t);
		check("relock", 1, t <= LMAX);
		cfg <= 1'b0;
		repeat (3) @(posedge clk);
		check("lock deconfig", 0, lck);
		check("oe deconfig", 0, {loe, coe});
		$display("test loss done");
		stop_test();
	end : main
endmodule : pcm_pll_ctrl_tb_top
bind pcm_pll_ctrl pcm_pll_ctrl_assertions #(.NUM_PLL(NUM_PLL)) pcm_pll_ctrl_assertions_i (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .config_done_in(config_done_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .lock_pin_oe_out(lock_pin_oe_out),
	.clk_pin_oe_out(clk_pin_oe_out), .core_clk_out(core_clk_out), .locked_out(locked_out));
